/* File: hdl/ltc_pkg.sv */
package ltc_pkg;
   // Bit positions inside the device control octet (bit 1 is index 0).
   localparam int CTL_CRC_OK      = 0;
   localparam int CTL_STARTUP_N   = 1;
   localparam int CTL_LOOP_N      = 2;
   localparam int CTL_FILTER_RST  = 3;
   localparam int CTL_LOCAL_DEACT = 4;
   localparam int CTL_RSVD        = 5;
   localparam int CTL_TEST        = 6;
   localparam int CTL_TRANSP      = 7;
   // Quiet value of the control octet: inactive, no loopback, reserved 1.
   localparam logic [7:0] CTL_RESET = 8'h26;
   // Clock rate and the transceiver-active hold-off time.
   localparam longint CLK_HZ       = 10000000;
   localparam longint XACT_DROP_MS = 480;
   localparam longint XACT_DROP_CYC = (CLK_HZ / 1000) * XACT_DROP_MS;
   // Superframes of deactivation warning sent before the line goes quiet.
   localparam logic [2:0] DEA_SFRAMES = 3'h3;
   // Channel data patterns forced during reset, idle and transparency.
   localparam logic [17:0] CH_ONES  = 18'h3FFFF;
   localparam logic [17:0] CH_ZEROS = 18'h00000;
   localparam logic [11:0] OVH_ONES = 12'hFFF;
   // Host register offsets over APB.
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   // Transceiver state codes.
   typedef enum logic [2:0] {
      LTC_IDLE   = 3'b000,
      LTC_ACTIVE = 3'b001,
      LTC_DEACT  = 3'b010,
      LTC_LOOP   = 3'b011,
      LTC_FRST   = 3'b100
   } ltc_state_t;
endpackage

/* File: hdl/ltc_if.sv */
`timescale 1ns/1ns
// Link between the system device and the transceiver; one octet per frame.
interface ltc_if;
   import ltc_pkg::*;
   logic       frame_sync;  // One-cycle pulse marking a system frame.
   logic [7:0] ctrl_octet;  // Device control octet from the system.
   logic       xact;        // Transceiver active status.
   logic       test_echo;   // Reflected test bit.
   modport dev  (input frame_sync, input ctrl_octet,
                 output xact, output test_echo);
   modport host (output frame_sync, output ctrl_octet,
                 input xact, input test_echo);
endinterface

/* File: hdl/ltc_device.sv */
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module ltc_device
   import ltc_pkg::*;
#(
   parameter longint DROP_CYC = XACT_DROP_CYC
)(
   input  wire logic        CLK_SYS,
   input  wire logic        SRST,
   ltc_if.dev               LNK,
   input  wire logic        NT_MODE,
   input  wire logic        SIG_LOST,
   input  wire logic        SFRAME_END,
   input  wire logic [17:0] TX_CH_IN,
   input  wire logic [17:0] RX_CH_IN,
   input  wire logic [11:0] RX_OVH_IN,
   output logic      [17:0] TX_CH_LINE,
   output logic      [17:0] RX_CH_OUT,
   output logic      [11:0] RX_OVH_OUT,
   output logic             CRC_CORRUPT,
   output logic             LINE_TX_EN,
   output logic             LOOPBACK,
   output logic             ECHO_CANC_EN,
   output logic             DESCR_LOOP,
   output logic             COEF_CLEAR,
   output logic             COEF_SAVE,
   output logic             DEA_WARN_N,
   output logic             FRAME_ALIGN_KEEP
);

   ////////////////////////////////////////////////////////////////////////
   // Control octet capture.

   logic [7:0]  ctl;        // Octet in force for the current frame.
   ltc_state_t  state;      // Transceiver state.
   logic [2:0]  sf_cnt;     // Warning superframes already sent.
   logic [31:0] drop_cnt;   // Hold-off count before active falls.
   logic        drop_run;   // Hold-off running.
   logic        xact;       // Active status, local copy.
   logic        up;         // Channels carry traffic.
   logic        drop_end;   // Hold-off reaches its last cycle.

   // Last count of the hold-off; active falls on the edge that sees it.
   assign drop_end = drop_run && (drop_cnt == 32'(DROP_CYC - 1));

   // The octet is taken whole at the frame pulse so no half-written
   // control ever steers the logic.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ctl <= CTL_RESET;
      end else if (LNK.frame_sync) begin
         ctl <= LNK.ctrl_octet;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Start-up, deactivation and loopback sequencing.

   // Filter reset wins over every other control, like the reset pin.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         state  <= LTC_IDLE;
         sf_cnt <= 3'h0;
      end else if (ctl[CTL_FILTER_RST]) begin
         state  <= LTC_FRST;
         sf_cnt <= 3'h0;
      end else begin
         unique case (state)
            LTC_FRST: begin
               state <= LTC_IDLE;
            end
            LTC_IDLE: begin
               // Start-up is only honoured while inactive.
               if (!ctl[CTL_LOOP_N]) begin
                  state <= LTC_LOOP;
               end else if (!xact && !ctl[CTL_STARTUP_N]) begin
                  state <= LTC_ACTIVE;
               end
            end
            LTC_ACTIVE: begin
               // Without this exit a lost line would let active drop and
               // rise again one cycle later while still in this state.
               if (drop_end) begin
                  state <= LTC_IDLE;
               end else if (!ctl[CTL_LOOP_N]) begin
                  state <= LTC_LOOP;
               end else if (ctl[CTL_LOCAL_DEACT]) begin
                  state  <= LTC_DEACT;
                  sf_cnt <= 3'h0;
               end
            end
            LTC_DEACT: begin
               if (!ctl[CTL_LOCAL_DEACT]) begin
                  state <= LTC_ACTIVE;
               end else if (NT_MODE) begin
                  if (SIG_LOST) begin
                     state <= LTC_IDLE;
                  end
               end else if (SFRAME_END) begin
                  // LT: warn for a fixed count of superframes, then quit.
                  if (sf_cnt == DEA_SFRAMES) begin
                     state <= LTC_IDLE;
                  end else begin
                     sf_cnt <= sf_cnt + 3'h1;
                  end
               end
            end
            LTC_LOOP: begin
               if (ctl[CTL_LOOP_N]) begin
                  state <= LTC_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transceiver active status with its 480 ms fall.

   // Active rises on start-up; it falls at once on reset or filter reset,
   // and only after the hold-off when the line is lost or deactivated.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         xact     <= 1'b0;
         drop_run <= 1'b0;
         drop_cnt <= 32'h0;
      end else if (state == LTC_FRST) begin
         xact     <= 1'b0;
         drop_run <= 1'b0;
         drop_cnt <= 32'h0;
      end else if (drop_run) begin
         // Hold-off in progress; only reset or a filter reset cuts it short.
         if (drop_end) begin
            xact     <= 1'b0;
            drop_run <= 1'b0;
            drop_cnt <= 32'h0;
         end else begin
            drop_cnt <= drop_cnt + 32'h1;
         end
      end else if (state == LTC_ACTIVE && !xact) begin
         xact <= 1'b1;
      end else if (xact && (SIG_LOST || state == LTC_IDLE)) begin
         // Line lost or state left to idle: start the hold-off.
         drop_run <= 1'b1;
      end
   end
   assign LNK.xact = xact;

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs.

   // Deactivation, reset, loopback and idle all force ones toward the
   // system; only the active state carries traffic.
   assign up = (state == LTC_ACTIVE);

   // Data toward the system: ones unless traffic flows; transparency
   // never touches this direction.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         RX_CH_OUT  <= CH_ONES;
         RX_OVH_OUT <= OVH_ONES;
      end else begin
         RX_CH_OUT  <= up ? RX_CH_IN : CH_ONES;
         RX_OVH_OUT <= up ? RX_OVH_IN : OVH_ONES;
      end
   end

   // Data toward the line, with transparency forcing per mode.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         TX_CH_LINE <= CH_ONES;
      end else if (ctl[CTL_TRANSP]) begin
         TX_CH_LINE <= NT_MODE ? CH_ONES : CH_ZEROS;
      end else begin
         TX_CH_LINE <= TX_CH_IN;
      end
   end

   // Line and analog controls derived from state and octet.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         CRC_CORRUPT      <= 1'b0;
         LINE_TX_EN       <= 1'b0;
         LOOPBACK         <= 1'b0;
         ECHO_CANC_EN     <= 1'b1;
         DESCR_LOOP       <= 1'b0;
         COEF_CLEAR       <= 1'b0;
         COEF_SAVE        <= 1'b0;
         DEA_WARN_N       <= 1'b1;
         FRAME_ALIGN_KEEP <= 1'b0;
         LNK.test_echo    <= 1'b0;
      end else begin
         CRC_CORRUPT      <= !ctl[CTL_CRC_OK];
         LINE_TX_EN       <= state == LTC_ACTIVE || state == LTC_DEACT
                             || state == LTC_LOOP;
         LOOPBACK         <= state == LTC_LOOP;
         ECHO_CANC_EN     <= state != LTC_LOOP;
         DESCR_LOOP       <= state == LTC_LOOP;
         COEF_CLEAR       <= state == LTC_FRST;
         COEF_SAVE        <= state == LTC_DEACT;
         DEA_WARN_N       <= !(state == LTC_DEACT && !NT_MODE);
         FRAME_ALIGN_KEEP <= state == LTC_FRST && !NT_MODE;
         LNK.test_echo    <= ctl[CTL_TEST];
      end
   end

endmodule

/* File: hdl/ltc_host.sv */
`timescale 1ns/1ns
// System-side end: APB control word mirrored onto the link each frame.
module ltc_host
   import ltc_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        SRST,
   ltc_if.host              LNK,
   input  wire logic        FRAME_TICK,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [3:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR
);

   ////////////////////////////////////////////////////////////////////////
   // Control register and status sampling.

   logic [7:0] ctrl;   // Software control octet.
   logic       xact_s; // Synchronised active status.
   logic       echo_s; // Synchronised test echo.

   // The reserved bit is forced high whatever software writes.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         ctrl <= CTL_RESET;
      end else if (PSEL && PENABLE && PWRITE && PADDR == REG_CTRL) begin
         ctrl <= PWDATA[7:0] | 8'h20;
      end
   end

   // Status from the other end is already on this clock; one stage only.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         xact_s <= 1'b0;
         echo_s <= 1'b0;
      end else begin
         xact_s <= LNK.xact;
         echo_s <= LNK.test_echo;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link drive: octet presented with every frame pulse.

   // Software must keep start-up high in loopback and ccrc high in
   // operation; this end only forwards its choice.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         LNK.frame_sync <= 1'b0;
         LNK.ctrl_octet <= CTL_RESET;
      end else begin
         LNK.frame_sync <= FRAME_TICK;
         if (FRAME_TICK) begin
            LNK.ctrl_octet <= ctrl;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB slave: zero wait states, error on unmapped offsets.

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         PRDATA  <= 32'h0;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && PADDR != REG_CTRL
                    && PADDR != REG_STATUS;
         if (PSEL && !PENABLE) begin
            PRDATA <= (PADDR == REG_CTRL) ? {24'h0, ctrl} :
                      (PADDR == REG_STATUS) ? {30'h0, echo_s, xact_s} :
                      32'h0;
         end
      end
   end

endmodule

/* File: sim/ltc_checker.sv */
`timescale 1ns/1ns
// Watches the link between the system end and the transceiver end.
module ltc_checker
   import ltc_pkg::*;
(
   input wire logic       CLK_SYS,
   input wire logic       SRST,
   input wire logic       frame_sync,
   input wire logic [7:0] ctrl_octet,
   input wire logic       xact,
   input wire logic       test_echo
);
   logic [7:0] lat_oct; // Octet as the device should hold it.

   //////////////////////////////////////////////////////////////////////
   // Mirror of the frame latch, so checks see whole octets only.
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         lat_oct <= CTL_RESET;
      end else if (frame_sync) begin
         lat_oct <= ctrl_octet;
      end
   end

   //////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   // A frame that carries a filter reset.
   sequence s_frst;
      frame_sync && ctrl_octet[CTL_FILTER_RST];
   endsequence
   property p_pulse;
      frame_sync |=> !frame_sync;
   endproperty
   property p_oct_hold;
      $changed(ctrl_octet) |-> frame_sync;
   endproperty
   property p_rsvd;
      frame_sync |-> ctrl_octet[CTL_RSVD];
   endproperty
   property p_echo;
      frame_sync |=> ##[0:3] (test_echo == lat_oct[CTL_TEST]);
   endproperty
   property p_echo_src;
      $changed(test_echo) |-> (test_echo == lat_oct[CTL_TEST]);
   endproperty
   property p_rise;
      $rose(xact) |-> !lat_oct[CTL_STARTUP_N] && !lat_oct[CTL_FILTER_RST];
   endproperty
   property p_stay_off;
      !xact && lat_oct[CTL_STARTUP_N] && !frame_sync |=> !xact;
   endproperty
   property p_frst;
      s_frst |-> ##[1:4] !xact;
   endproperty

   a_pulse: assert property (p_pulse)
      else $error("frame sync longer than one cycle");
   a_oct_hold: assert property (p_oct_hold)
      else $error("control octet changed between frames");
   a_rsvd: assert property (p_rsvd)
      else $error("reserved control bit sent low");
   a_echo: assert property (p_echo)
      else $error("test bit not reflected");
   a_echo_src: assert property (p_echo_src)
      else $error("reflected test bit changed on its own");
   a_rise: assert property (p_rise)
      else $error("active rose without a start request");
   a_stay_off: assert property (p_stay_off)
      else $error("active rose while start-up held off");
   a_frst: assert property (p_frst)
      else $error("filter reset left transceiver active");
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ns
// Drives both ends over APB and the line-side inputs, checks outputs.
module tb_top;
   import ltc_pkg::*;
   logic        clk_sys = 1'b0;  // 10 MHz system clock.
   logic        srst    = 1'b1;  // Synchronous reset.
   logic [7:0]  fcnt    = 8'h00; // Frame and superframe timer.
   logic        frame_tick = 1'b0, sframe_end = 1'b0;
   logic        nt_mode = 1'b0, sig_lost = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [3:0]  paddr  = 4'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er;
   logic [17:0] tx_in = 18'h2A5C3, rx_in = 18'h1B4E7, tx_line, rx_out;
   logic [11:0] ovh_in = 12'h5A6, ovh_out;
   logic        crc_c, tx_en, lpb, ec_en, dsc, cclr, csav, warn_n, fak;
   int          n_mismatch = 0, checks_done = 0;

   ltc_if lnk();
   ltc_device #(.DROP_CYC(20)) u_ltc_device (.CLK_SYS(clk_sys),
      .SRST(srst), .LNK(lnk), .NT_MODE(nt_mode), .SIG_LOST(sig_lost),
      .SFRAME_END(sframe_end), .TX_CH_IN(tx_in), .RX_CH_IN(rx_in),
      .RX_OVH_IN(ovh_in), .TX_CH_LINE(tx_line), .RX_CH_OUT(rx_out),
      .RX_OVH_OUT(ovh_out), .CRC_CORRUPT(crc_c), .LINE_TX_EN(tx_en),
      .LOOPBACK(lpb), .ECHO_CANC_EN(ec_en), .DESCR_LOOP(dsc),
      .COEF_CLEAR(cclr), .COEF_SAVE(csav), .DEA_WARN_N(warn_n),
      .FRAME_ALIGN_KEEP(fak));
   ltc_host u_ltc_host (.CLK_SYS(clk_sys), .SRST(srst), .LNK(lnk),
      .FRAME_TICK(frame_tick), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr));
   ltc_checker u_ltc_checker (.CLK_SYS(clk_sys), .SRST(srst),
      .frame_sync(lnk.frame_sync), .ctrl_octet(lnk.ctrl_octet),
      .xact(lnk.xact), .test_echo(lnk.test_echo));

   //////////////////////////////////////////////////////////////////////
   always #50 clk_sys = ~clk_sys;
   // Frames every 16 cycles; superframe ends share the frame rate.
   always @(posedge clk_sys) begin
      fcnt <= fcnt + 8'h01;
      frame_tick <= (fcnt[3:0] == 4'hF);
      sframe_end <= (fcnt[3:0] == 4'h7);
   end

   //////////////////////////////////////////////////////////////////////
   // Compares one value; an unknown never matches.
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // One APB transfer; waits for PREADY without assuming its latency.
   task automatic apb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // Control write, then one frame plus the latch pipeline.
   task automatic wr(input logic [7:0] d);
      apb(1'b1, REG_CTRL, {24'h0, d});
      repeat (24) @(posedge clk_sys);
   endtask
   // Waits for the active status under a bounded count.
   task automatic wx(input logic v);
      int n;
      n = 0;
      while (lnk.xact !== v && n < 400) begin
         @(posedge clk_sys);
         n++;
      end
      chk(lnk.xact, v);
   endtask
   task automatic end_of_test;
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   //////////////////////////////////////////////////////////////////////
   // A hung handshake would stall here; the watchdog ends the run.
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      chk(lnk.xact, 0);
      chk(rx_out, CH_ONES);
      chk(ovh_out, OVH_ONES);
      apb(1'b0, 4'h8, 32'h0);
      chk(er, 1);
      wr(8'h66);
      apb(1'b0, REG_STATUS, 32'h0);
      chk(rd, 32'h2);
      wr(8'h25);
      wx(1);
      chk(tx_en, 1);
      chk(tx_line, tx_in);
      chk(rx_out, rx_in);
      chk(ovh_out, ovh_in);
      chk(crc_c, 0);
      wr(8'h27);
      chk(lnk.xact, 1);
      wr(8'hA5);
      chk(tx_line, CH_ZEROS);
      chk(rx_out, rx_in);
      nt_mode <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk(tx_line, CH_ONES);
      nt_mode <= 1'b0;
      wr(8'h24);
      chk(crc_c, 1);
      // Start-up held high so the transceiver stays inactive afterwards.
      wr(8'h37);
      chk(csav, 1);
      chk(rx_out, CH_ONES);
      chk(warn_n, 0);
      wx(0);
      chk(tx_en, 0);
      wr(8'h25);
      wx(1);
      wr(8'h2D);
      chk(lnk.xact, 0);
      chk({cclr, tx_en, rx_out}, {2'b10, CH_ONES});
      chk(fak, 1);
      wr(8'h23);
      chk({lpb, ec_en, dsc}, 3'b101);
      nt_mode <= 1'b1;
      wr(8'h25);
      wx(1);
      // Local deactivate held until active falls, start-up high.
      wr(8'h37);
      chk(warn_n, 1);
      sig_lost <= 1'b1;
      wx(0);
      end_of_test();
   end
endmodule
